// ===== src/rtc_timer.sv
// Sixteen-bit real-time-clock timer with Wishbone register access.
// Operation
// R1 - Clock select 01 moves CPU and peripherals onto the timer oscillator.
// R2 - Sleep in secondary run with idle enable clear enters secondary idle.
// R3 - Read-only status flag is set while the timer oscillator clocks system.
// R4 - With clock monitor on, oscillator failure hands the clock elsewhere.
// R5 - Low-power configuration bit selects oscillator power; default is high.
// R6 - Sixteen-bit count runs 0000h to FFFFh then wraps to 0000h.
// R7 - Each wrap latches the overflow flag until software clears it.
// R8 - Interrupt request is raised only while overflow enable is set.
// R9 - Special event trigger from a compare unit in mode 1011 clears count.
// R10 - Second compare unit trigger also starts a conversion if converter on.
// R11 - Trigger reset is only guaranteed in timer or synchronous counter mode.
// R12 - Trigger resets make the compare value act as the count period.
// R13 - A count write in the same cycle as a trigger wins over it.
// R14 - Trigger reset from second compare unit never sets overflow flag.
// R15 - Software sets high byte top bit after overflow for one second.
// R16 - Software leaves the low byte untouched when preloading.
// R17 - Software keeps asynchronous mode, interrupt and oscillator running.
// R18 - Wide mode: low-byte read copies live high byte into a buffer.
// R19 - Wide mode: low-byte write loads buffered high byte; clears prescale.
// R20 - Overflow flag sets in the wrap cycle; cleared only by writing zero.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "rtc_timer_regs.svh"

module rtc_timer #(
   parameter int CNT_W = 16
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        CLK_EN,
   // Wishbone classic slave.
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // Secondary oscillator and power control.
   input  wire logic        SEC_OSC_IN,
   input  wire logic        SEC_OSC_FAIL,
   input  wire logic        FAIL_MON_EN,
   input  wire logic        LOW_POWER_OSC_CFG,
   input  wire logic        SLEEP_EXEC,
   input  wire logic        WAKE_EVENT,
   output logic             SEC_OSC_ENABLE,
   output logic             SEC_OSC_LOW_POWER,
   output logic             SYS_CLK_FROM_SEC,
   output logic             CPU_CLK_GATED,
   output logic             PERIPH_CLK_GATED,
   // Compare units and converter.
   input  wire logic [3:0]  COMPARE_A_MODE_FIELD,
   input  wire logic [3:0]  COMPARE_B_MODE_FIELD,
   input  wire logic        COMPARE_A_EVENT,
   input  wire logic        COMPARE_B_EVENT,
   input  wire logic        ADC_ENABLED,
   output logic             ADC_START,
   output logic             OVERFLOW_IRQ
);

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [7:0]       hi_buf_r;
   logic [6:0]       ctrl_r;
   logic             ovf_flag_r;
   logic             ovf_en_r;
   logic             idle_en_r;
   logic [1:0]       clk_sel_r;
   rtc_pkg::rtc_pm_t pm_r;
   rtc_pkg::rtc_pm_t pm_nxt;
   logic             acc;
   logic             wr;
   logic             rd;
   logic             tick;
   logic             wr_lo;
   logic             wr_hi;
   logic             rd_lo;
   logic             trig_a;
   logic             trig_b;
   logic             trig_ok;
   logic             trig_rst;
   logic             wrap;
   logic             ps_clr;
   logic             sec_clocking;
   logic             fail_now;
   logic [31:0]      rd_data;

   // Byte-wide register write test; lane 0 carries every field.
   function automatic logic hit_wr(input logic [7:0] off);
      hit_wr = wr && (WB_ADR_I == off) && WB_SEL_I[0];
   endfunction

   // A trigger only counts when its unit is in special event mode.
   function automatic logic special_trig(input logic [3:0] mode,
                                         input logic       ev);
      special_trig = ev && (mode == `RTC_CMP_SPECIAL);
   endfunction

   // ************************************************************
   // Bus decode.
   // ************************************************************

   // A request is taken once; ack follows one cycle later.
   assign acc   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr    = acc && WB_WE_I;
   assign rd    = acc && !WB_WE_I;
   assign rd_lo = rd && (WB_ADR_I == `RTC_OFF_CNT_LO);
   // A process, so bus reads inside the function wake it.
   always_comb begin
      wr_lo = hit_wr(`RTC_OFF_CNT_LO);
      wr_hi = hit_wr(`RTC_OFF_CNT_HI);
   end

   // Only low-byte writes restart the prescaler.
   assign ps_clr = wr_lo; // R19

   // ************************************************************
   // Count source and prescaler.
   // ************************************************************
   rtc_tick u_tick (
      .clk     (SYS_CLK),
      .rst_n   (RST_N),
      .ce      (CLK_EN),
      .run     (ctrl_r[`RTC_CTRL_ON]),
      .src_ext (ctrl_r[`RTC_CTRL_SRC]),
      .ext_in  (SEC_OSC_IN),
      .ps_sel  (ctrl_r[`RTC_CTRL_PS_HI:`RTC_CTRL_PS_LO]),
      .ps_clr  (ps_clr),
      .tick    (tick)
   );

   // ************************************************************
   // Special event triggers.
   // ************************************************************
   assign trig_a = special_trig(COMPARE_A_MODE_FIELD, COMPARE_A_EVENT); // R9
   assign trig_b = special_trig(COMPARE_B_MODE_FIELD, COMPARE_B_EVENT); // R9

   // Asynchronous counter mode drops the reset; it is not guaranteed there.
   assign trig_ok  = !(ctrl_r[`RTC_CTRL_SRC] &&
                       ctrl_r[`RTC_CTRL_NOSYNC]); // R11
   assign trig_rst = (trig_a || trig_b) && trig_ok; // R12

   // A wrap only happens by counting; trigger resets never raise it.
   assign wrap = tick && (count_r == CNT_W'(`RTC_CNT_MAX)) // R6
                 && !trig_rst && !wr_lo && !wr_hi; // R14

   // ************************************************************
   // Next count: writes first, then trigger reset, then counting.
   // ************************************************************
   always_comb begin
      count_nxt = count_r;
      if (wr_lo || wr_hi) begin
         if (wr_lo) begin
            count_nxt[7:0] = WB_DAT_I[7:0]; // R13
            if (ctrl_r[`RTC_CTRL_WIDE-1]) begin
               count_nxt[15:8] = hi_buf_r; // R19
            end
         end
         if (wr_hi && !ctrl_r[`RTC_CTRL_WIDE-1]) begin
            count_nxt[15:8] = WB_DAT_I[7:0];
         end
      end else if (trig_rst) begin
         count_nxt = CNT_W'(`RTC_CNT_RST); // R9
      end else if (tick) begin
         count_nxt = count_r + CNT_W'(1); // R6
      end
   end

   // Count register pair.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         count_r <= CNT_W'(`RTC_CNT_RST);
      end else if (CLK_EN) begin
         count_r <= count_nxt;
      end
   end

   // ************************************************************
   // High-byte buffer for wide access.
   // ************************************************************

   // A low-byte read freezes the high byte so a pair read is coherent.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         hi_buf_r <= 8'h00;
      end else if (CLK_EN) begin
         if (rd_lo && ctrl_r[`RTC_CTRL_WIDE-1]) begin
            hi_buf_r <= count_r[15:8]; // R18
         end else if (wr_hi && ctrl_r[`RTC_CTRL_WIDE-1]) begin
            hi_buf_r <= WB_DAT_I[7:0]; // R19
         end
      end
   end

   // ************************************************************
   // Overflow flag, enable and interrupt request.
   // ************************************************************

   // The wrap sets the flag in its own cycle; a set beats a clear.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ovf_flag_r <= 1'b0;
      end else if (CLK_EN) begin
         if (wrap) begin
            ovf_flag_r <= 1'b1; // R7
         end else if (hit_wr(`RTC_OFF_IRQ_FLAG) &&
                      !WB_DAT_I[`RTC_IRQ_OVF]) begin
            ovf_flag_r <= 1'b0; // R20
         end
      end
   end

   // Enable bit.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ovf_en_r <= 1'b0;
      end else if (CLK_EN && hit_wr(`RTC_OFF_IRQ_EN)) begin
         ovf_en_r <= WB_DAT_I[`RTC_IRQ_OVF];
      end
   end

   // Request follows the flag and enable one cycle later.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         OVERFLOW_IRQ <= 1'b0;
      end else if (CLK_EN) begin
         OVERFLOW_IRQ <= ovf_flag_r && ovf_en_r; // R8
      end
   end

   // Conversion start pulse from the second unit's trigger.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ADC_START <= 1'b0;
      end else if (CLK_EN) begin
         ADC_START <= trig_b && ADC_ENABLED; // R10
      end
   end

   // ************************************************************
   // Control registers.
   // ************************************************************

   // Counter control; the flag bit is not stored, wide is bit 6.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ctrl_r <= `RTC_CTRL_RST;
      end else if (CLK_EN && hit_wr(`RTC_OFF_CTRL)) begin
         ctrl_r <= {WB_DAT_I[`RTC_CTRL_WIDE],
                    WB_DAT_I[`RTC_CTRL_PS_HI:`RTC_CTRL_ON]};
      end
   end

   // Oscillator control: idle enable and clock select.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         idle_en_r <= 1'(`RTC_OSC_RST >> `RTC_OSC_IDLE_ON_SLEEP_ENABLE);
         clk_sel_r <= 2'h0;
      end else if (CLK_EN && hit_wr(`RTC_OFF_OSC_CTRL)) begin
         idle_en_r <= WB_DAT_I[`RTC_OSC_IDLE_ON_SLEEP_ENABLE];
         clk_sel_r <= WB_DAT_I[`RTC_OSC_SCS_HI:`RTC_OSC_SCS_LO];
      end
   end

   // ************************************************************
   // Power states.
   // ************************************************************

   // A failed oscillator only forces a fallback while monitoring is on.
   assign fail_now = FAIL_MON_EN && SEC_OSC_FAIL; // R4

   always_comb begin
      pm_nxt = pm_r;
      unique case (pm_r)
         rtc_pkg::PM_PRI_RUN: begin
            if (SLEEP_EXEC) begin
               pm_nxt = rtc_pkg::PM_SLEEP;
            end else if (clk_sel_r == `RTC_SCS_SEC && !fail_now) begin
               pm_nxt = rtc_pkg::PM_SEC_RUN; // R1
            end
         end
         rtc_pkg::PM_SEC_RUN: begin
            if (fail_now || clk_sel_r != `RTC_SCS_SEC) begin
               pm_nxt = rtc_pkg::PM_PRI_RUN; // R4
            end else if (SLEEP_EXEC) begin
               pm_nxt = idle_en_r ? rtc_pkg::PM_SLEEP
                                  : rtc_pkg::PM_SEC_IDLE; // R2
            end
         end
         rtc_pkg::PM_SEC_IDLE: begin
            if (fail_now) begin
               pm_nxt = rtc_pkg::PM_PRI_RUN; // R4
            end else if (WAKE_EVENT) begin
               pm_nxt = rtc_pkg::PM_SEC_RUN;
            end
         end
         rtc_pkg::PM_SLEEP: begin
            if (WAKE_EVENT) begin
               pm_nxt = (clk_sel_r == `RTC_SCS_SEC && !fail_now)
                        ? rtc_pkg::PM_SEC_RUN : rtc_pkg::PM_PRI_RUN;
            end
         end
      endcase
   end

   // State register.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pm_r <= rtc_pkg::PM_PRI_RUN;
      end else if (CLK_EN) begin
         pm_r <= pm_nxt;
      end
   end

   // The status flag follows the state, so it drops on a fallback.
   assign sec_clocking = (pm_r == rtc_pkg::PM_SEC_RUN) ||
                         (pm_r == rtc_pkg::PM_SEC_IDLE); // R3

   // Clock routing outputs, all registered.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         SYS_CLK_FROM_SEC  <= 1'b0;
         CPU_CLK_GATED     <= 1'b0;
         PERIPH_CLK_GATED  <= 1'b0;
         SEC_OSC_ENABLE    <= 1'b0;
         SEC_OSC_LOW_POWER <= 1'b0;
      end else if (CLK_EN) begin
         SYS_CLK_FROM_SEC  <= (pm_nxt == rtc_pkg::PM_SEC_RUN) ||
                              (pm_nxt == rtc_pkg::PM_SEC_IDLE); // R1
         CPU_CLK_GATED     <= (pm_nxt == rtc_pkg::PM_SEC_IDLE) ||
                              (pm_nxt == rtc_pkg::PM_SLEEP); // R2
         PERIPH_CLK_GATED  <= pm_nxt == rtc_pkg::PM_SLEEP;
         // Oscillator stays on while it clocks the system.
         SEC_OSC_ENABLE    <= ctrl_r[`RTC_CTRL_OSCEN] ||
                              (pm_nxt != rtc_pkg::PM_PRI_RUN &&
                               pm_nxt != rtc_pkg::PM_SLEEP);
         SEC_OSC_LOW_POWER <= LOW_POWER_OSC_CFG; // R5
      end
   end

   // ************************************************************
   // Read multiplexer and acknowledge.
   // ************************************************************
   always_comb begin
      rd_data = 32'h0000_0000;
      unique case (WB_ADR_I)
         `RTC_OFF_CTRL: begin
            rd_data[`RTC_CTRL_WIDE] = ctrl_r[6];
            rd_data[`RTC_CTRL_RUN]  = sec_clocking; // R3
            rd_data[`RTC_CTRL_PS_HI:0] = ctrl_r[`RTC_CTRL_PS_HI:0];
         end
         `RTC_OFF_CNT_LO: begin
            rd_data[7:0] = count_r[7:0];
         end
         `RTC_OFF_CNT_HI: begin
            rd_data[7:0] = ctrl_r[`RTC_CTRL_WIDE-1] ? hi_buf_r
                                                    : count_r[15:8]; // R18
         end
         `RTC_OFF_IRQ_FLAG: begin
            rd_data[`RTC_IRQ_OVF] = ovf_flag_r;
         end
         `RTC_OFF_IRQ_EN: begin
            rd_data[`RTC_IRQ_OVF] = ovf_en_r;
         end
         `RTC_OFF_OSC_CTRL: begin
            rd_data[`RTC_OSC_IDLE_ON_SLEEP_ENABLE] = idle_en_r;
            rd_data[`RTC_OSC_SCS_HI:`RTC_OSC_SCS_LO] = clk_sel_r;
         end
         `RTC_OFF_PM_STAT: begin
            rd_data[1:0] = pm_r;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // Every address answers; unmapped ones read zero and drop writes.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
      end else if (CLK_EN) begin
         WB_ACK_O <= acc;
         if (rd) begin
            WB_DAT_O <= rd_data;
         end
      end
   end

endmodule

// ===== src/rtc_timer_regs.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef RTC_TIMER_REGS_SVH
`define RTC_TIMER_REGS_SVH

// ************************************************************
// Register byte offsets on the bus.
// ************************************************************
`define RTC_OFF_CTRL      8'h00
`define RTC_OFF_CNT_LO    8'h04
`define RTC_OFF_CNT_HI    8'h08
`define RTC_OFF_IRQ_FLAG  8'h0C
`define RTC_OFF_IRQ_EN    8'h10
`define RTC_OFF_OSC_CTRL  8'h14
`define RTC_OFF_PM_STAT   8'h18

// ************************************************************
// Field positions of the counter control register.
// ************************************************************
`define RTC_CTRL_WIDE     7
`define RTC_CTRL_RUN      6
`define RTC_CTRL_PS_HI    5
`define RTC_CTRL_PS_LO    4
`define RTC_CTRL_OSCEN    3
`define RTC_CTRL_NOSYNC   2
`define RTC_CTRL_SRC      1
`define RTC_CTRL_ON       0

// ************************************************************
// Field positions of the other registers.
// ************************************************************
`define RTC_IRQ_OVF       0
`define RTC_OSC_IDLE_ON_SLEEP_ENABLE     7
`define RTC_OSC_SCS_HI    1
`define RTC_OSC_SCS_LO    0

// ************************************************************
// Reset values and codes.
// ************************************************************
`define RTC_CTRL_RST      7'h00
`define RTC_OSC_RST       8'h00
`define RTC_CNT_RST       16'h0000
`define RTC_CNT_MAX       16'hFFFF
`define RTC_SCS_SEC       2'h1
`define RTC_CMP_SPECIAL   4'hB
`define RTC_PS_BITS       3

`endif

// ===== src/rtc_pkg.sv
// Types shared by the real-time-clock timer modules.
package rtc_pkg;

   // Power states of the system clock selection.
   typedef enum logic [1:0] {
      PM_PRI_RUN,
      PM_SEC_RUN,
      PM_SEC_IDLE,
      PM_SLEEP
   } rtc_pm_t;

endpackage

// ===== src/rtc_tick.sv
// Count-source selection, input synchroniser and prescaler of the timer.
`timescale 1ns/10ps
`include "rtc_timer_regs.svh"

module rtc_tick #(
   parameter int PS_W = `RTC_PS_BITS
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic       run,
   input  wire logic       src_ext,
   input  wire logic       ext_in,
   input  wire logic [1:0] ps_sel,
   input  wire logic       ps_clr,
   output logic            tick
);

   logic            sync1_r;
   logic            sync2_r;
   logic            sync3_r;
   logic            edge_w;
   logic            src_w;
   logic [PS_W-1:0] ps_r;
   logic [PS_W-1:0] ps_nxt;
   logic [PS_W-1:0] ps_mask;

   // ************************************************************
   // Input synchroniser; only sync2 and sync3 feed the edge test.
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end else if (ce) begin
         sync1_r <= ext_in;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // External source counts on its rising edge, internal on every cycle.
   assign edge_w  = sync2_r & ~sync3_r;
   assign src_w   = src_ext ? edge_w : 1'b1;
   assign ps_mask = PS_W'((1 << ps_sel) - 1);
   assign ps_nxt  = ps_r + PS_W'(1);

   // Prescaler; cleared on demand so a low-byte write restarts a period.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ps_r <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         tick <= 1'b0;
         if (ps_clr || !run) begin
            ps_r <= '0;
         end else if (src_w) begin
            if ((ps_r & ps_mask) == ps_mask) begin
               ps_r <= '0;
               tick <= 1'b1;
            end else begin
               ps_r <= ps_nxt;
            end
         end
      end
   end

endmodule

// ===== tb/rtc_timer_chk.sv
// Port-level concurrent checks for the real-time-clock timer.
`timescale 1ns/10ps
module rtc_timer_chk (
   input wire logic       SYS_CLK,
   input wire logic       RST_N,
   input wire logic       CLK_EN,
   input wire logic       WB_CYC_I,
   input wire logic       WB_STB_I,
   input wire logic       WB_ACK_O,
   input wire logic       SLEEP_EXEC,
   input wire logic       SEC_OSC_FAIL,
   input wire logic       FAIL_MON_EN,
   input wire logic       LOW_POWER_OSC_CFG,
   input wire logic       SEC_OSC_LOW_POWER,
   input wire logic       SYS_CLK_FROM_SEC,
   input wire logic       CPU_CLK_GATED,
   input wire logic       PERIPH_CLK_GATED,
   input wire logic [3:0] COMPARE_B_MODE_FIELD,
   input wire logic       COMPARE_B_EVENT,
   input wire logic       ADC_ENABLED,
   input wire logic       ADC_START
);
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);

   // A request the slave must take, and a held oscillator failure.
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O && CLK_EN;
   endsequence
   sequence s_fail;
      (FAIL_MON_EN && SEC_OSC_FAIL && CLK_EN) [*3];
   endsequence

   chk_ack_next: assert property (s_req |=> WB_ACK_O)
      else $error("ack missing after request");
   chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   chk_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without request");
   chk_adc_cause: assert property (
      ADC_START |-> $past(COMPARE_B_EVENT && ADC_ENABLED &&
                          COMPARE_B_MODE_FIELD == 4'hB))
      else $error("conversion start without trigger");
   chk_lp_copy: assert property (
      CLK_EN |=> SEC_OSC_LOW_POWER == $past(LOW_POWER_OSC_CFG))
      else $error("oscillator power level not followed");
   chk_sleep_both: assert property (PERIPH_CLK_GATED |-> CPU_CLK_GATED)
      else $error("peripherals halted while cpu runs");
   chk_idle_sec: assert property (
      CPU_CLK_GATED && !PERIPH_CLK_GATED |-> SYS_CLK_FROM_SEC)
      else $error("idle without secondary clock");
   chk_sleep_halt: assert property (
      SLEEP_EXEC && CLK_EN && SYS_CLK_FROM_SEC && !SEC_OSC_FAIL
      |=> ##[0:2] CPU_CLK_GATED)
      else $error("sleep in secondary run did not halt cpu");
   chk_fail_leave: assert property (s_fail |-> !SYS_CLK_FROM_SEC)
      else $error("failed oscillator still clocks system");
endmodule

// ===== tb/rtc_osc_model.sv
// Behavioural crystal that feeds the timer oscillator input.
`timescale 1ns/10ps
module rtc_osc_model #(
   parameter int HALF = 5
) (
   input  wire logic clk,
   input  wire logic broken,
   output logic      osc,
   output logic      fail
);
   int cnt = 0;

   initial osc = 1'b0;
   // The crystal runs at all times; a dead one stops toggling.
   always @(posedge clk) begin
      cnt <= (cnt >= HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1 && !broken)
         osc <= !osc;
   end
   // The clock monitor sees a stopped crystal at once.
   assign fail = broken;
endmodule

// ===== tb/test_rtc_timer.sv
// Self-checking bench for the real-time-clock timer.
`timescale 1ns/10ps
`include "rtc_timer_regs.svh"
module test_rtc_timer;
   logic        SYS_CLK = 1'b0;
   logic        RST_N = 1'b0;
   logic        CLK_EN = 1'b1;
   logic        WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
   logic [7:0]  WB_ADR_I = 8'h00;
   logic [3:0]  WB_SEL_I = 4'hF;
   logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O, rd;
   logic        WB_ACK_O, SEC_OSC_IN, SEC_OSC_FAIL, FAIL_MON_EN = 1'b0;
   logic        LOW_POWER_OSC_CFG = 1'b0, SLEEP_EXEC = 1'b0;
   logic        WAKE_EVENT = 1'b0, SEC_OSC_ENABLE, SEC_OSC_LOW_POWER;
   logic        SYS_CLK_FROM_SEC, CPU_CLK_GATED, PERIPH_CLK_GATED;
   logic [3:0]  COMPARE_A_MODE_FIELD = 4'h0, COMPARE_B_MODE_FIELD = 4'h0;
   logic        COMPARE_A_EVENT = 1'b0, COMPARE_B_EVENT = 1'b0;
   logic        ADC_ENABLED = 1'b0, ADC_START, OVERFLOW_IRQ, broken = 1'b0;
   int          miscompares = 0, comparisons = 0, cycles = 0;

   rtc_timer i_rtc_timer (.*);
   rtc_osc_model i_rtc_osc_model (.clk(SYS_CLK), .broken(broken),
                                  .osc(SEC_OSC_IN), .fail(SEC_OSC_FAIL));

   // ***************
   // Shared tasks.
   // ***************
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge SYS_CLK);
   endtask
   // One classic cycle; ev pulses compare unit A at the taking edge.
   task automatic bus(logic we, logic [7:0] adr, logic [7:0] d, logic ev);
      @(posedge SYS_CLK);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= we;
      WB_ADR_I <= adr;
      WB_DAT_I <= {24'h0, d};
      COMPARE_A_EVENT <= ev;
      do begin
         @(posedge SYS_CLK);
         COMPARE_A_EVENT <= 1'b0;
      end while (WB_ACK_O !== 1'b1);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
   endtask
   task automatic wr(logic [7:0] adr, logic [7:0] d);
      bus(1'b1, adr, d, 1'b0);
   endtask
   task automatic rdck(string what, logic [7:0] adr, logic [31:0] exp);
      bus(1'b0, adr, 8'h00, 1'b0);
      check(what, rd, exp);
   endtask
   task automatic pulse_b(logic [31:0] exp);
      @(posedge SYS_CLK);
      COMPARE_B_EVENT <= 1'b1;
      @(posedge SYS_CLK);
      COMPARE_B_EVENT <= 1'b0;
      @(posedge SYS_CLK);
      check("adc start", 32'(ADC_START), exp);
   endtask
   task automatic nap(logic [31:0] pm, logic [31:0] per);
      @(posedge SYS_CLK);
      SLEEP_EXEC <= 1'b1;
      @(posedge SYS_CLK);
      SLEEP_EXEC <= 1'b0;
      tick(3);
      check("cpu halted", 32'(CPU_CLK_GATED), 32'h1);
      check("periph halted", 32'(PERIPH_CLK_GATED), per);
      rdck("power state", `RTC_OFF_PM_STAT, pm);
      WAKE_EVENT <= 1'b1;
      @(posedge SYS_CLK);
      WAKE_EVENT <= 1'b0;
      tick(3);
   endtask

   // ***************
   // Scenarios.
   // ***************
   task automatic t_wrap();
      rdck("ctrl reset", `RTC_OFF_CTRL, 32'h0);
      rdck("unmapped", 8'h1C, 32'h0);
      wr(`RTC_OFF_CNT_HI, 8'hFF);
      wr(`RTC_OFF_CNT_LO, 8'hFE);
      rdck("flag early", `RTC_OFF_IRQ_FLAG, 32'h0);
      wr(`RTC_OFF_CTRL, 8'h01);
      tick(8);
      wr(`RTC_OFF_CTRL, 8'h00);
      rdck("flag set", `RTC_OFF_IRQ_FLAG, 32'h1);
      rdck("count wrapped", `RTC_OFF_CNT_HI, 32'h0);
      check("irq masked", 32'(OVERFLOW_IRQ), 32'h0);
      wr(`RTC_OFF_IRQ_EN, 8'h01);
      tick(2);
      check("irq raised", 32'(OVERFLOW_IRQ), 32'h1);
      wr(`RTC_OFF_IRQ_FLAG, 8'h01);
      rdck("flag kept", `RTC_OFF_IRQ_FLAG, 32'h1);
      wr(`RTC_OFF_IRQ_FLAG, 8'h00);
      tick(2);
      check("irq dropped", 32'(OVERFLOW_IRQ), 32'h0);
      $display("test wrap done");
   endtask
   task automatic t_trig();
      ADC_ENABLED <= 1'b1;
      COMPARE_A_MODE_FIELD <= 4'hA;
      COMPARE_B_MODE_FIELD <= 4'hB;
      wr(`RTC_OFF_CNT_HI, 8'h80);
      bus(1'b0, `RTC_OFF_CTRL, 8'h00, 1'b1);
      rdck("wrong mode", `RTC_OFF_CNT_HI, 32'h80);
      pulse_b(32'h1);
      rdck("b reset lo", `RTC_OFF_CNT_LO, 32'h0);
      rdck("b reset hi", `RTC_OFF_CNT_HI, 32'h0);
      rdck("no flag", `RTC_OFF_IRQ_FLAG, 32'h0);
      COMPARE_A_MODE_FIELD <= 4'hB;
      wr(`RTC_OFF_CNT_HI, 8'h12);
      bus(1'b1, `RTC_OFF_CNT_LO, 8'h55, 1'b1);
      rdck("write wins lo", `RTC_OFF_CNT_LO, 32'h55);
      rdck("write wins hi", `RTC_OFF_CNT_HI, 32'h12);
      wr(`RTC_OFF_CTRL, 8'h06);
      bus(1'b1, `RTC_OFF_CTRL, 8'h00, 1'b1);
      rdck("async", `RTC_OFF_CNT_HI, 32'h12);
      bus(1'b0, `RTC_OFF_CTRL, 8'h00, 1'b1);
      rdck("a reset", `RTC_OFF_CNT_HI, 32'h0);
      ADC_ENABLED <= 1'b0;
      pulse_b(32'h0);
      $display("test trigger done");
   endtask
   task automatic t_wide();
      wr(`RTC_OFF_CTRL, 8'h80);
      wr(`RTC_OFF_CNT_HI, 8'hAB);
      wr(`RTC_OFF_CTRL, 8'h00);
      rdck("hi waits", `RTC_OFF_CNT_HI, 32'h0);
      wr(`RTC_OFF_CTRL, 8'h80);
      wr(`RTC_OFF_CNT_LO, 8'hCD);
      wr(`RTC_OFF_CNT_HI, 8'h77);
      rdck("lo wide", `RTC_OFF_CNT_LO, 32'hCD);
      rdck("hi buffer", `RTC_OFF_CNT_HI, 32'hAB);
      wr(`RTC_OFF_CTRL, 8'h00);
      rdck("hi live", `RTC_OFF_CNT_HI, 32'hAB);
      $display("test wide done");
   endtask
   task automatic t_power();
      LOW_POWER_OSC_CFG <= 1'b1;
      wr(`RTC_OFF_OSC_CTRL, 8'h01);
      tick(3);
      check("low power", 32'(SEC_OSC_LOW_POWER), 32'h1);
      check("sec clock", 32'(SYS_CLK_FROM_SEC), 32'h1);
      check("osc on", 32'(SEC_OSC_ENABLE), 32'h1);
      rdck("run flag", `RTC_OFF_CTRL, 32'h40);
      rdck("sec run", `RTC_OFF_PM_STAT, 32'h1);
      nap(32'h2, 32'h0);
      wr(`RTC_OFF_OSC_CTRL, 8'h81);
      nap(32'h3, 32'h1);
      FAIL_MON_EN <= 1'b1;
      broken <= 1'b1;
      tick(4);
      check("fail clock", 32'(SYS_CLK_FROM_SEC), 32'h0);
      rdck("fail flag", `RTC_OFF_CTRL, 32'h0);
      broken <= 1'b0;
      wr(`RTC_OFF_OSC_CTRL, 8'h00);
      tick(3);
      rdck("primary", `RTC_OFF_CTRL, 32'h0);
      $display("test power done");
   endtask

   // Free-running clock and a hang guard well above the run length.
   initial forever #4 SYS_CLK = ~SYS_CLK;
   always @(posedge SYS_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         results();
      end
   end

   // Main sequence.
   initial begin
      repeat (4) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      t_wrap();
      t_trig();
      t_wide();
      t_power();
      results();
   end
endmodule

bind rtc_timer rtc_timer_chk i_rtc_timer_chk (.*);
